//--- core/gpx_pkg.sv
// Purpose: Shared constants for the serial GPIO expander slave
// Assumes: 40 MHz system clock, 16 port pins in two 8-bit ports
// Notes: Command codes select one register of four pairs
package gpx_pkg;
  localparam int unsigned GPX_CLK_HZ = 40_000_000; // System clock rate
  localparam logic [2:0] GPX_CMD_IN0 = 3'h0; // Input port 0
  localparam logic [2:0] GPX_CMD_IN1 = 3'h1; // Input port 1
  localparam logic [2:0] GPX_CMD_OUT0 = 3'h2; // Output port 0
  localparam logic [2:0] GPX_CMD_OUT1 = 3'h3; // Output port 1
  localparam logic [2:0] GPX_CMD_POL0 = 3'h4; // Polarity inversion 0
  localparam logic [2:0] GPX_CMD_POL1 = 3'h5; // Polarity inversion 1
  localparam logic [2:0] GPX_CMD_CFG0 = 3'h6; // Configuration 0
  localparam logic [2:0] GPX_CMD_CFG1 = 3'h7; // Configuration 1
  localparam logic [7:0] GPX_RST_OUT = 8'hFF; // Output reset value
  localparam logic [7:0] GPX_RST_POL = 8'h00; // Polarity reset value
  localparam logic [7:0] GPX_RST_CFG = 8'hFF; // Configuration reset value
  localparam logic [6:0] GPX_DEF_ADDR = 7'h20; // Default slave address
  localparam int unsigned GPX_BIT_CNT_W = 3; // Bit counter width
  localparam logic [2:0] GPX_LAST_BIT = 3'h7; // Index of last bit of a byte
  localparam int unsigned GPX_SYNC_STAGES = 3; // Pin synchroniser depth
endpackage

//--- core/gpx_port.sv
// Purpose: One 8-bit port: pin drive, polarity and change detect
// Assumes: Pin levels arrive already synchronised
// Notes: Snapshot reload on input register read clears the request
`timescale 1ns/1ps
module gpx_port #(
  parameter bit OPEN_DRAIN = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_pin, // Synchronised pin levels
  input wire logic [7:0] i_out, // Output register
  input wire logic [7:0] i_pol, // Polarity inversion
  input wire logic [7:0] i_cfg, // 1 = input
  input wire logic i_rd_snap, // Input register read pulse
  output logic [7:0] o_in_val, // Value reported for input register
  output logic [7:0] o_pin_o,
  output logic [7:0] o_pin_oe,
  output logic o_chg // Change pending on this port
);
  logic [7:0] snap_q, snap_d; // Pin levels at last read
  logic [7:0] po_q, po_d, poe_q, poe_d; // Registered drive

  assign o_in_val = i_pin ^ i_pol;
  // Only input pins count; returning to old level drops the request
  assign o_chg = |((i_pin ^ snap_q) & i_cfg);

  // Next drive and snapshot
  always_comb begin
    snap_d = i_rd_snap ? i_pin : snap_q;
    for (int i = 0; i < 8; i++) begin
      if (i_cfg[i]) begin
        po_d[i] = 1'b0;
        poe_d[i] = 1'b0;
      end else if (OPEN_DRAIN) begin
        po_d[i] = 1'b0;
        poe_d[i] = ~i_out[i];
      end else begin
        po_d[i] = i_out[i];
        poe_d[i] = 1'b1;
      end
    end
  end

  // Register drive and snapshot
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      snap_q <= 8'h00;
      po_q <= 8'h00;
      poe_q <= 8'h00;
    end else begin
      snap_q <= snap_d;
      po_q <= po_d;
      poe_q <= poe_d;
    end
  end

  assign o_pin_o = po_q;
  assign o_pin_oe = poe_q;
endmodule

//--- core/gpx_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pins
// Assumes: Input is asynchronous to I_CLOCK
// Notes: Output changes only when stages two and three agree
`timescale 1ns/1ps
module gpx_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q; // Raw stages
  logic [WIDTH-1:0] filt_q, filt_d; // Filtered level

  // An empty bundle has nothing to filter
  if (WIDTH < 1) begin : g_bad_width
    $error("gpx_sync needs WIDTH of at least 1");
  end

  // Only accept a level once two stages agree; first stage feeds only the second
  always_comb begin
    filt_d = filt_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        filt_d[i] = s3_q[i];
      end
    end
  end

  // Register the stages
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      filt_q <= RST_VAL;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  assign o_sync = filt_q;
endmodule

//--- core/gpx_top.sv
// Purpose: Serial-bus slave giving access to a 16-bit GPIO expander
// Assumes: SCL and SDA sampled by I_CLOCK at 40 MHz, well above bus rate
// Notes: Slave address is a parameter; pin strap decoding omitted
// Summary of operation
// - Input pins have both drivers off
// - Push-pull drives level; open-drain only pulls low
// - Write bytes alternate within register pair
// - Any number of bytes per write
// - Transmit data loaded at ack falling edge
// - Read bytes alternate within pair, unlimited
// - STOP returns slave to idle anytime
// - Input pin change asserts active-low interrupt
// - Interrupt clears on return or read
// - Output pins never cause interrupts
// - Interrupt causes tracked per port
// - Output-to-input switch may raise interrupt
// - One bit per SCL pulse, stable high
// - START and STOP from SDA edges
// - Slave acknowledges every received byte once its own address matches
// - Acknowledger holds SDA low during pulse
// - Slave releases SDA after missing ack
// - Commands 0 to 7 map registers
// - Polarity bit inverts reported input
// - Configuration 1 input, 0 output
// - Reset: config ones, output ones, polarity zeros
`timescale 1ns/1ps
module gpx_top
  import gpx_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = GPX_DEF_ADDR,
  parameter bit OPEN_DRAIN = 1'b0
) (
  input wire logic I_CLOCK,
  input wire logic I_RSTN,
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA_O,
  output logic O_SDA_OE,
  output logic O_INT_N_O,
  output logic O_INT_N_OE,
  input wire logic [15:0] I_IO,
  output logic [15:0] O_IO_O,
  output logic [15:0] O_IO_OE
);
  typedef enum logic [2:0] {
    GPX_IDLE, GPX_ADDR, GPX_CMD, GPX_WDAT, GPX_RDAT, GPX_ACK_OUT, GPX_ACK_IN, GPX_SKIP
  } gpx_state_e;

  logic scl_s, sda_s, scl_p_q, sda_p_q; // Filtered bus lines and previous
  logic [15:0] pin_s; // Filtered port pins
  logic scl_rise, scl_fall, start_c, stop_c;
  gpx_state_e st_q, st_d, ack_ret_q, ack_ret_d; // State and post-ack state
  logic [2:0] bit_q, bit_d; // Bit index within byte
  logic [7:0] sh_q, sh_d; // Receive/transmit shift register
  logic [2:0] ptr_q, ptr_d; // Register pointer (command)
  logic first_q, first_d; // SCL fall that ends a START is not a bit
  logic sda_oe_q, sda_oe_d; // Pull SDA low
  logic nack_q, nack_d; // Master did not acknowledge
  logic [7:0] out0_q, out0_d, out1_q, out1_d;
  logic [7:0] pol0_q, pol0_d, pol1_q, pol1_d;
  logic [7:0] cfg0_q, cfg0_d, cfg1_q, cfg1_d;
  logic [7:0] in0_v, in1_v, rd_val;
  logic rd0, rd1, chg0, chg1;

  gpx_sync #(.WIDTH(2), .RST_VAL(2'b11)) u_bus_sync (
    .i_clk(I_CLOCK),
    .i_rstn(I_RSTN),
    .i_async({I_SCL, I_SDA}),
    .o_sync({scl_s, sda_s})
  );
  gpx_sync #(.WIDTH(16), .RST_VAL(16'h0000)) u_pin_sync (
    .i_clk(I_CLOCK),
    .i_rstn(I_RSTN),
    .i_async(I_IO),
    .o_sync(pin_s)
  );

  // Line edges and bus conditions
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // Register select for reads
  always_comb begin
    unique case (ptr_q)
      GPX_CMD_IN0: rd_val = in0_v;
      GPX_CMD_IN1: rd_val = in1_v;
      GPX_CMD_OUT0: rd_val = out0_q;
      GPX_CMD_OUT1: rd_val = out1_q;
      GPX_CMD_POL0: rd_val = pol0_q;
      GPX_CMD_POL1: rd_val = pol1_q;
      GPX_CMD_CFG0: rd_val = cfg0_q;
      GPX_CMD_CFG1: rd_val = cfg1_q;
    endcase
  end

  // Protocol engine next state
  always_comb begin
    st_d = st_q;
    ack_ret_d = ack_ret_q;
    bit_d = bit_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    first_d = first_q;
    sda_oe_d = sda_oe_q;
    nack_d = nack_q;
    out0_d = out0_q;
    out1_d = out1_q;
    pol0_d = pol0_q;
    pol1_d = pol1_q;
    cfg0_d = cfg0_q;
    cfg1_d = cfg1_q;
    rd0 = 1'b0;
    rd1 = 1'b0;
    if (start_c) begin
      // Start or repeated start: collect the address byte
      st_d = GPX_ADDR;
      bit_d = '0;
      first_d = 1'b1; // Master drops SCL once before the first bit
      sda_oe_d = 1'b0;
    end else if (stop_c) begin
      st_d = GPX_IDLE;
      sda_oe_d = 1'b0;
    end else begin
      unique case (st_q)
        GPX_IDLE, GPX_SKIP: begin
          sda_oe_d = 1'b0;
        end
        GPX_ADDR, GPX_CMD, GPX_WDAT: begin
          if (scl_fall && first_q) begin
            first_d = 1'b0; // Would otherwise count a phantom bit
          end else if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_s};
          end else if (scl_fall && bit_q == GPX_LAST_BIT) begin
            bit_d = '0;
            if (st_q == GPX_ADDR && sh_q[7:1] != SLAVE_ADDR) begin
              st_d = GPX_SKIP; // Not us: stay off the bus
            end else begin
              sda_oe_d = 1'b1;
              st_d = GPX_ACK_OUT;
              if (st_q == GPX_ADDR) begin
                ack_ret_d = sh_q[0] ? GPX_RDAT : GPX_CMD;
              end else if (st_q == GPX_CMD) begin
                ptr_d = sh_q[2:0];
                ack_ret_d = GPX_WDAT;
              end else begin
                // Store then flip within the pair
                unique case (ptr_q)
                  GPX_CMD_OUT0: out0_d = sh_q;
                  GPX_CMD_OUT1: out1_d = sh_q;
                  GPX_CMD_POL0: pol0_d = sh_q;
                  GPX_CMD_POL1: pol1_d = sh_q;
                  GPX_CMD_CFG0: cfg0_d = sh_q;
                  GPX_CMD_CFG1: cfg1_d = sh_q;
                  default: ; // Input registers ignore writes
                endcase
                ptr_d = ptr_q ^ 3'h1;
                ack_ret_d = GPX_WDAT;
              end
            end
          end else if (scl_fall) begin
            bit_d = bit_q + 3'h1;
          end
        end
        GPX_ACK_OUT: begin
          if (scl_fall) begin
            // Ack pulse over: release, or load transmit byte
            st_d = ack_ret_q;
            sda_oe_d = 1'b0;
            if (ack_ret_q == GPX_RDAT) begin
              sh_d = rd_val;
              rd0 = (ptr_q == GPX_CMD_IN0);
              rd1 = (ptr_q == GPX_CMD_IN1);
              sda_oe_d = ~rd_val[7];
            end
          end
        end
        GPX_RDAT: begin
          if (scl_fall && bit_q == GPX_LAST_BIT) begin
            bit_d = '0;
            sda_oe_d = 1'b0; // Release for master's ack
            st_d = GPX_ACK_IN;
          end else if (scl_fall) begin
            bit_d = bit_q + 3'h1;
            sh_d = {sh_q[6:0], 1'b1};
            sda_oe_d = ~sh_q[6];
          end
        end
        GPX_ACK_IN: begin
          if (scl_rise) begin
            nack_d = sda_s;
          end else if (scl_fall) begin
            if (nack_q) begin
              st_d = GPX_SKIP;
              sda_oe_d = 1'b0;
            end else begin
              // Next byte from the other register of the pair
              sh_d = rd_val;
              rd0 = (ptr_q == GPX_CMD_IN0);
              rd1 = (ptr_q == GPX_CMD_IN1);
              sda_oe_d = ~rd_val[7];
              st_d = GPX_RDAT;
            end
          end
        end
      endcase
    end
    // Advance pointer after each byte fetched for transmit
    if (st_d == GPX_RDAT && st_q != GPX_RDAT) begin
      ptr_d = ptr_q ^ 3'h1;
    end
  end

  // Protocol and register file
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      st_q <= GPX_IDLE;
      ack_ret_q <= GPX_IDLE;
      bit_q <= '0;
      sh_q <= 8'h00;
      ptr_q <= GPX_CMD_IN0;
      first_q <= 1'b0;
      sda_oe_q <= 1'b0;
      nack_q <= 1'b0;
      out0_q <= GPX_RST_OUT;
      out1_q <= GPX_RST_OUT;
      pol0_q <= GPX_RST_POL;
      pol1_q <= GPX_RST_POL;
      cfg0_q <= GPX_RST_CFG;
      cfg1_q <= GPX_RST_CFG;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      st_q <= st_d;
      ack_ret_q <= ack_ret_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      first_q <= first_d;
      sda_oe_q <= sda_oe_d;
      nack_q <= nack_d;
      out0_q <= out0_d;
      out1_q <= out1_d;
      pol0_q <= pol0_d;
      pol1_q <= pol1_d;
      cfg0_q <= cfg0_d;
      cfg1_q <= cfg1_d;
    end
  end

  gpx_port #(.OPEN_DRAIN(OPEN_DRAIN)) u_port0 (
    .i_clk(I_CLOCK),
    .i_rstn(I_RSTN),
    .i_pin(pin_s[7:0]),
    .i_out(out0_q),
    .i_pol(pol0_q),
    .i_cfg(cfg0_q),
    .i_rd_snap(rd0),
    .o_in_val(in0_v),
    .o_pin_o(O_IO_O[7:0]),
    .o_pin_oe(O_IO_OE[7:0]),
    .o_chg(chg0)
  );
  gpx_port #(.OPEN_DRAIN(OPEN_DRAIN)) u_port1 (
    .i_clk(I_CLOCK),
    .i_rstn(I_RSTN),
    .i_pin(pin_s[15:8]),
    .i_out(out1_q),
    .i_pol(pol1_q),
    .i_cfg(cfg1_q),
    .i_rd_snap(rd1),
    .o_in_val(in1_v),
    .o_pin_o(O_IO_O[15:8]),
    .o_pin_oe(O_IO_OE[15:8]),
    .o_chg(chg1)
  );

  // Open-drain SDA and interrupt: only ever pull low
  assign O_SDA_O = 1'b0;
  assign O_SDA_OE = sda_oe_q;
  assign O_INT_N_O = 1'b0;
  assign O_INT_N_OE = chg0 | chg1;

  property p_stop_idle;
    @(posedge I_CLOCK) disable iff (!I_RSTN) stop_c |=> st_q == GPX_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not idle");
  property p_stop_release;
    @(posedge I_CLOCK) disable iff (!I_RSTN) stop_c |=> !sda_oe_q;
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("sda held");
  property p_ack_low;
    @(posedge I_CLOCK) disable iff (!I_RSTN) st_q == GPX_ACK_OUT |-> sda_oe_q;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack not driven");
  property p_reset_cfg;
    @(posedge I_CLOCK) $rose(I_RSTN) |-> cfg0_q == GPX_RST_CFG && out1_q == GPX_RST_OUT;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("bad reset value");
  property p_nack_release;
    @(posedge I_CLOCK) disable iff (!I_RSTN)
      st_q == GPX_ACK_IN && nack_q && scl_fall && !start_c && !stop_c |=> !sda_oe_q;
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("sda held");
  property p_int_out;
    @(posedge I_CLOCK) disable iff (!I_RSTN) rd0 ##1 $stable(pin_s[7:0]) |-> !chg0;
  endproperty
  a_int_out: assert property (p_int_out) else $error("read left request");
  property p_wr_pair;
    @(posedge I_CLOCK) disable iff (!I_RSTN)
      st_q == GPX_WDAT && scl_fall && bit_q == GPX_LAST_BIT && !start_c && !stop_c
      |=> ptr_q == ($past(ptr_q) ^ 3'h1);
  endproperty
  a_wr_pair: assert property (p_wr_pair) else $error("pair not alternated");
  property p_in_hiz;
    @(posedge I_CLOCK) disable iff (!I_RSTN) cfg0_q == 8'hFF ##1 cfg0_q == 8'hFF
      |-> O_IO_OE[7:0] == 8'h00;
  endproperty
  a_in_hiz: assert property (p_in_hiz) else $error("input driven");
  property p_read_load;
    @(posedge I_CLOCK) disable iff (!I_RSTN)
      st_q == GPX_ACK_OUT && ack_ret_q == GPX_RDAT && scl_fall && !start_c && !stop_c
      |=> st_q == GPX_RDAT && sh_q == $past(rd_val);
  endproperty
  a_read_load: assert property (p_read_load) else $error("tx not loaded");
  c_write: cover property (@(posedge I_CLOCK) st_q == GPX_WDAT ##1 st_q == GPX_ACK_OUT);
  c_read: cover property (@(posedge I_CLOCK) st_q == GPX_ACK_IN ##1 st_q == GPX_RDAT);
  c_int: cover property (@(posedge I_CLOCK) $rose(O_INT_N_OE));
endmodule

//--- verif/gpx_i2c_host.sv
// Purpose: Behavioural bus master driving SCL and pulling SDA low
// Assumes: Bus lines have pull-ups; a released SDA reads high
// Notes: gap stretches the low phase to act as a slow master
`timescale 1ns/1ps
module gpx_i2c_host (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  int gap = 0; // Extra low-phase clocks, set by the bench

  // Idle bus: both lines high, SCL stands still
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // Wait n clocks, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // One bit; SDA only moves while SCL is low
  task automatic bit_xfer(input logic b, output logic r);
    o_scl = 1'b0;
    tick(1);
    o_sda_low = ~b;
    tick(4 + gap);
    o_scl = 1'b1;
    tick(3);
    r = i_sda;
  endtask

  // Start or repeated start: SDA falls while SCL high
  task automatic start();
    o_scl = 1'b0;
    tick(1);
    o_sda_low = 1'b0;
    tick(4 + gap);
    o_scl = 1'b1;
    tick(4);
    o_sda_low = 1'b1;
    tick(4);
  endtask

  // Stop: SDA rises while SCL high, bus left idle
  task automatic stop();
    o_scl = 1'b0;
    tick(1);
    o_sda_low = 1'b1;
    tick(4 + gap);
    o_scl = 1'b1;
    tick(4);
    o_sda_low = 1'b0;
    tick(4);
  endtask

  // Byte out, most significant bit first, then the ninth bit
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask

  // Byte in; the last one is left unacknowledged
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
    bit_xfer(last, r);
  endtask
endmodule

//--- verif/tb_top.sv
// Purpose: Self-checking bench for the GPIO expander slave
// Assumes: Push-pull variant, default slave address
// Notes: Register pairs and pin levels are modelled here
`timescale 1ns/1ps
module tb_top;
  import gpx_pkg::*;
  logic clk = 1'b0; // System clock
  logic rstn = 1'b0; // Active-low reset
  logic [15:0] io_ext = 16'h0000; // Level applied to undriven pins
  logic [31:0] seed = 32'h0001_35AC; // Fixed seed, repeatable runs
  logic [7:0] rg [8]; // Expected register contents
  int n_mismatch = 0;
  int n_tests = 0;
  logic scl, sda_low, sda_oe, sda_o, int_oe, int_o;
  logic [15:0] io_o, io_oe;
  wire logic sda = !(sda_low || (sda_oe && !sda_o)); // Pulled-up line
  wire logic int_act = int_oe && !int_o; // Interrupt pulled low
  // Driven pins show the drive, others the outside level
  wire logic [15:0] io_pin = (io_oe & io_o) | (~io_oe & io_ext);

  // Clock generator
  always #12.5 clk = ~clk;

  gpx_i2c_host host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

  gpx_top DUT (
    .I_CLOCK(clk), .I_RSTN(rstn), .I_SCL(scl), .I_SDA(sda), .O_SDA_O(sda_o),
    .O_SDA_OE(sda_oe), .O_INT_N_O(int_o), .O_INT_N_OE(int_oe), .I_IO(io_pin),
    .O_IO_O(io_o), .O_IO_OE(io_oe));

  // Xorshift source of random bytes
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  // Expected input register of port p
  function automatic logic [7:0] in_exp(int p);
    return ((rg[6+p] & io_ext[p*8+:8]) | (~rg[6+p] & rg[2+p])) ^ rg[4+p];
  endfunction

  task automatic chk_bit(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t ns: flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t ns: byte %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t ns: pins %h expected %h", $time, g, e);
    end
  endtask

  // Verdict and end of run
  task automatic test_done();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Byte out with expected acknowledge
  task automatic send(input logic [7:0] d, input logic e);
    logic a;
    host.wr_byte(d, a);
    chk_bit(a, e);
  endtask

  // Write n bytes from command c, first byte d0, rest random
  task automatic wr_regs(input logic [2:0] c, input int n, input logic [7:0] d0);
    logic [2:0] p;
    logic [7:0] d;
    p = c;
    d = d0;
    host.start();
    send({GPX_DEF_ADDR, 1'b0}, 1'b1);
    send({5'h00, c}, 1'b1);
    for (int i = 0; i < n; i++) begin
      send(d, 1'b1);
      if (p > 3'h1) rg[p] = d;
      p[0] = ~p[0];
      d = xs();
    end
    host.stop();
  endtask

  // Read n bytes from command c through a repeated start
  task automatic rd_regs(input logic [2:0] c, input int n);
    logic [2:0] p;
    logic [7:0] d;
    p = c;
    host.start();
    send({GPX_DEF_ADDR, 1'b0}, 1'b1);
    send({5'h00, c}, 1'b1);
    host.start();
    send({GPX_DEF_ADDR, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      host.rd_byte(i == n - 1, d);
      chk_byte(d, p < 3'h2 ? in_exp(int'(p)) : rg[p]);
      p[0] = ~p[0];
    end
    chk_bit(sda_oe, 1'b0);
    host.stop();
  endtask

  // Bounded wait for the interrupt to reach level e
  task automatic wait_int(input logic e);
    int k;
    k = 0;
    while (int_act !== e && k < 40) begin
      host.tick(1);
      k++;
    end
    chk_bit(int_act, e);
    // A wait that runs out ends the run
    if (int_act !== e) begin
      test_done();
    end
  endtask

  // Main sequence
  initial begin
    logic [7:0] e0;
    rg = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF};
    io_ext = {xs(), xs()};
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    host.tick(8);
    chk_word(io_oe, 16'h0000);
    for (int c = 2; c < 8; c += 2) rd_regs(c[2:0], 2);
    // Foreign address is ignored
    host.start();
    send({GPX_DEF_ADDR ^ 7'h01, 1'b0}, 1'b0);
    host.stop();
    // STOP right after the command byte
    host.start();
    send({GPX_DEF_ADDR, 1'b0}, 1'b1);
    send({5'h00, GPX_CMD_OUT1}, 1'b1);
    host.stop();
    // Every command, random data and lengths; slow master on odd ones
    for (int c = 0; c < 8; c++) begin
      host.gap = (c % 2) * 6;
      wr_regs(c[2:0], 1 + int'(xs() % 4), xs());
      io_ext = {xs(), xs()};
      host.tick(10);
      chk_word(io_oe, ~{rg[7], rg[6]});
      chk_word(io_o | {rg[7], rg[6]}, {rg[3], rg[2]} | {rg[7], rg[6]});
      rd_regs(3'(xs()), 1 + int'(xs() % 4));
    end
    // Interrupt: all pins inputs, both ports read first
    host.gap = 0;
    wr_regs(GPX_CMD_CFG0, 1, 8'hFF);
    wr_regs(GPX_CMD_CFG1, 1, 8'hFF);
    host.tick(10);
    rd_regs(GPX_CMD_IN0, 2);
    wait_int(1'b0);
    io_ext[9] = ~io_ext[9];
    wait_int(1'b1);
    rd_regs(GPX_CMD_IN0, 1);
    host.tick(10);
    chk_bit(int_act, 1'b1);
    io_ext[9] = ~io_ext[9];
    wait_int(1'b0);
    io_ext[3] = ~io_ext[3];
    wait_int(1'b1);
    rd_regs(GPX_CMD_IN0, 1);
    wait_int(1'b0);
    // Output pin toggles quietly, then turns input at the new level
    e0 = io_ext[7:0];
    wr_regs(GPX_CMD_OUT0, 1, {rg[2][7:1], ~e0[0]});
    wr_regs(GPX_CMD_CFG0, 1, 8'hFE);
    host.tick(10);
    chk_bit(int_act, 1'b0);
    io_ext[0] = ~e0[0];
    wr_regs(GPX_CMD_CFG0, 1, 8'hFF);
    wait_int(1'b1);
    test_done();
  end
endmodule
